// ### design/dcfg_top.sv
/*
  Data path configuration block: register file on AXI4-Lite, DMA
  address and lane steering, FIFO bus request thresholds, loopback and
  send-packet gating.
  Assumes the FIFO level, DMA strobes and send command are synchronous
  to aclk and come from the surrounding network controller.
*/
`timescale 1ns/100ps
`default_nettype none

module dcfg_top #(
  parameter int FIFO_LVL_W = 5
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // ---------------------------------------------------------------
  // DMA side
  // ---------------------------------------------------------------
  input  wire logic                  dma_load,
  input  wire logic [15:0]           dma_base,
  input  wire logic                  dma_step,
  input  wire logic [15:0]           dma_wdata,
  output logic [31:0]                mem_addr,
  output logic [15:0]                mem_data,
  output logic                       word_xfer,
  // ---------------------------------------------------------------
  // FIFO and control
  // ---------------------------------------------------------------
  input  wire logic [FIFO_LVL_W-1:0] fifo_level,
  input  wire logic                  rx_active,
  output logic                       bus_req,
  output logic [4:0]                 burst_len,
  input  wire logic                  send_cmd,
  output logic                       auto_init_start,
  output logic                       send_ignored,
  output logic                       loopback_en,
  output logic [1:0]                 loop_mode,
  output logic                       endec_loopback
);

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [7:0]  dpc_q, dpc_d;
  logic [1:0]  loop_q, loop_d;
  logic [15:0] rsa_q, rsa_d;

  logic        wr_en;
  logic [5:0]  wr_idx;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic [5:0]  rd_idx;
  logic [31:0] rd_data;
  logic        rd_ok;

  logic        word_mode, lane_swap, wide_mode, loop_sel_n, arm;
  logic [1:0]  ft;
  logic [4:0]  rx_th, tx_th;
  logic        bus_req_q;

  assign word_mode  = dpc_q[dcfg_pkg::DPC_WTS];
  assign lane_swap  = dpc_q[dcfg_pkg::DPC_BOS];
  assign wide_mode  = dpc_q[dcfg_pkg::DPC_LAS];
  assign loop_sel_n = dpc_q[dcfg_pkg::DPC_LS];
  assign arm        = dpc_q[dcfg_pkg::DPC_ARM];
  assign ft         = {dpc_q[dcfg_pkg::DPC_FTHI], dpc_q[dcfg_pkg::DPC_FTLO]};

  dcfg_axil u_axil (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .s_awaddr  (s_axi_awaddr),
    .s_awvalid (s_axi_awvalid),
    .s_awready (s_axi_awready),
    .s_wdata   (s_axi_wdata),
    .s_wstrb   (s_axi_wstrb),
    .s_wvalid  (s_axi_wvalid),
    .s_wready  (s_axi_wready),
    .s_bresp   (s_axi_bresp),
    .s_bvalid  (s_axi_bvalid),
    .s_bready  (s_axi_bready),
    .s_araddr  (s_axi_araddr),
    .s_arvalid (s_axi_arvalid),
    .s_arready (s_axi_arready),
    .s_rdata   (s_axi_rdata),
    .s_rresp   (s_axi_rresp),
    .s_rvalid  (s_axi_rvalid),
    .s_rready  (s_axi_rready),
    .wr_en     (wr_en),
    .wr_idx    (wr_idx),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .wr_ok     (wr_ok),
    .rd_idx    (rd_idx),
    .rd_data   (rd_data),
    .rd_ok     (rd_ok)
  );

  // status is read-only, everything else unmapped is an error
  assign wr_ok = dcfg_pkg::dcfg_mapped(wr_idx) && (wr_idx != dcfg_pkg::IDX_STAT);
  assign rd_ok = dcfg_pkg::dcfg_mapped(rd_idx);

  always_comb begin
    dpc_d  = dpc_q;
    loop_d = loop_q;
    rsa_d  = rsa_q;
    if (wr_en && wr_strb[0]) begin
      case (wr_idx)
        dcfg_pkg::IDX_DPC: begin
          // top bit is never stored
          dpc_d = wr_data[7:0] & dcfg_pkg::DPC_MASK;
        end
        dcfg_pkg::IDX_TXC: begin
          loop_d = wr_data[dcfg_pkg::TXC_LOOP_HI:dcfg_pkg::TXC_LOOP_LO];
        end
        dcfg_pkg::IDX_RSA: begin
          rsa_d[7:0] = wr_data[7:0];
        end
        default: begin
          dpc_d = dpc_q;
        end
      endcase
    end
    if (wr_en && wr_strb[1] && (wr_idx == dcfg_pkg::IDX_RSA)) begin
      rsa_d[15:8] = wr_data[15:8];
    end
  end

  // read side; data_path_config is write-only and reads as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_idx)
      dcfg_pkg::IDX_RSA: begin
        rd_data = {16'h0000, rsa_q};
      end
      dcfg_pkg::IDX_TXC: begin
        rd_data[dcfg_pkg::TXC_LOOP_HI:dcfg_pkg::TXC_LOOP_LO] = loop_q;
      end
      dcfg_pkg::IDX_STAT: begin
        rd_data = {3'h0, tx_th, 3'h0, rx_th, 7'h00, bus_req_q, dpc_q};
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dpc_q  <= dcfg_pkg::DPC_RST;
      loop_q <= dcfg_pkg::TXC_LOOP_RST;
      rsa_q  <= 16'h0000;
    end else begin
      dpc_q  <= dpc_d;
      loop_q <= loop_d;
      rsa_q  <= rsa_d;
    end
  end

  // ---------------------------------------------------------------
  // DMA transfer index, address and lanes
  // ---------------------------------------------------------------
  logic [15:0] idx_q, idx_d;
  logic [31:0] addr_c, mem_addr_q, mem_addr_d;
  logic [15:0] data_c, mem_data_q, mem_data_d;

  dcfg_path u_path (
    .word_mode (word_mode),
    .lane_swap (lane_swap),
    .wide_mode (wide_mode),
    .start_hi  (rsa_q),
    .xfer_idx  (idx_q),
    .data_in   (dma_wdata),
    .addr      (addr_c),
    .data_out  (data_c)
  );

  always_comb begin
    idx_d = idx_q;
    if (dma_load) begin
      idx_d = dma_base;
    end else if (dma_step) begin
      // one step is one byte or one word, whichever is selected
      idx_d = idx_q + 16'h0001;
    end
    mem_addr_d = addr_c;
    mem_data_d = data_c;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_q      <= 16'h0000;
      mem_addr_q <= 32'h0000_0000;
      mem_data_q <= 16'h0000;
    end else begin
      idx_q      <= idx_d;
      mem_addr_q <= mem_addr_d;
      mem_data_q <= mem_data_d;
    end
  end

  // ---------------------------------------------------------------
  // FIFO thresholds and bus request
  // ---------------------------------------------------------------
  logic       bus_req_d;
  logic [4:0] burst_q, burst_d;
  logic [4:0] lvl5;

  // level is counted in bytes whatever the transfer width
  assign lvl5  = 5'(fifo_level);
  assign rx_th = dcfg_pkg::dcfg_rx_bytes(ft);
  assign tx_th = dcfg_pkg::TX_THRESH_SUM - dcfg_pkg::dcfg_rx_bytes(ft);

  always_comb begin
    if (rx_active) begin
      bus_req_d = (lvl5 >= rx_th);
    end else begin
      bus_req_d = (lvl5 >= tx_th);
    end
    // burst counts transfers: words halve the byte figure
    burst_d = word_mode ? {1'b0, rx_th[4:1]} : rx_th;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_req_q <= 1'b0;
      burst_q   <= 5'h00;
    end else begin
      bus_req_q <= bus_req_d;
      burst_q   <= burst_d;
    end
  end

  // ---------------------------------------------------------------
  // send-packet gating and loopback
  // ---------------------------------------------------------------
  logic       start_q, start_d, ign_q, ign_d;
  logic       lben_q, lben_d, endec_q, endec_d;
  logic [1:0] lmode_q, lmode_d;

  always_comb begin
    start_d = send_cmd & arm;
    ign_d   = send_cmd & ~arm;
    // loopback follows the select bit alone: low enables it whatever the loop field
    lben_d  = ~loop_sel_n;
    lmode_d = loop_sel_n ? 2'h0 : loop_q;
    endec_d = ~loop_sel_n && (loop_q == dcfg_pkg::LOOP_ENDEC);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_q <= 1'b0;
      ign_q   <= 1'b0;
      lben_q  <= 1'b0;
      lmode_q <= 2'h0;
      endec_q <= 1'b0;
    end else begin
      start_q <= start_d;
      ign_q   <= ign_d;
      lben_q  <= lben_d;
      lmode_q <= lmode_d;
      endec_q <= endec_d;
    end
  end

  assign mem_addr        = mem_addr_q;
  assign mem_data        = mem_data_q;
  assign word_xfer       = dpc_q[dcfg_pkg::DPC_WTS];
  assign bus_req         = bus_req_q;
  assign burst_len       = burst_q;
  assign auto_init_start = start_q;
  assign send_ignored    = ign_q;
  assign loopback_en     = lben_q;
  assign loop_mode       = lmode_q;
  assign endec_loopback  = endec_q;

endmodule : dcfg_top

`default_nettype wire

// ### design/dcfg_pkg.sv
/*
  Constants, register map and helper functions for the data path
  configuration block.
  Assumes a 40 MHz single clock and an AXI4-Lite register bus with 32-bit data.
*/

package dcfg_pkg;

  // ---------------------------------------------------------------
  // register indexes, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_RSA  = 6'h08;
  localparam logic [5:0] IDX_TXC  = 6'h0D;
  localparam logic [5:0] IDX_DPC  = 6'h0E;
  localparam logic [5:0] IDX_STAT = 6'h10;

  // ---------------------------------------------------------------
  // data_path_config fields
  // ---------------------------------------------------------------
  localparam int         DPC_WTS  = 0;
  localparam int         DPC_BOS  = 1;
  localparam int         DPC_LAS  = 2;
  localparam int         DPC_LS   = 3;
  localparam int         DPC_ARM  = 4;
  localparam int         DPC_FTLO = 5;
  localparam int         DPC_FTHI = 6;
  localparam logic [7:0] DPC_MASK = 8'h7F;
  localparam logic [7:0] DPC_RST  = 8'h04;

  // transmit_config loop field and its reset
  localparam int         TXC_LOOP_LO = 1;
  localparam int         TXC_LOOP_HI = 2;
  localparam logic [1:0] TXC_LOOP_RST = 2'h0;
  localparam logic [1:0] LOOP_ENDEC   = 2'h2;

  // ---------------------------------------------------------------
  // thresholds and bus answers
  // ---------------------------------------------------------------
  localparam logic [4:0] TX_THRESH_SUM = 5'h0D;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // receive threshold in bytes for the encoded field
  function automatic logic [4:0] dcfg_rx_bytes(input logic [1:0] ft);
    logic [4:0] b;
    b = 5'h02;
    case (ft)
      2'h0:    b = 5'h02;
      2'h1:    b = 5'h04;
      2'h2:    b = 5'h08;
      default: b = 5'h0C;
    endcase
    return b;
  endfunction : dcfg_rx_bytes

  // known register index
  function automatic logic dcfg_mapped(input logic [5:0] idx);
    return (idx == IDX_RSA) || (idx == IDX_TXC) || (idx == IDX_DPC) || (idx == IDX_STAT);
  endfunction : dcfg_mapped

endpackage : dcfg_pkg

// ### design/dcfg_axil.sv
/*
  AXI4-Lite slave front end: takes one write and one read at a time and
  hands writes to the register file as single-cycle strobes and samples reads from rd_data.
  Assumes a master that follows AXI4-Lite handshakes.
*/
`timescale 1ns/100ps
`default_nettype none

module dcfg_axil (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  output logic             wr_en,
  output logic [5:0]       wr_idx,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_ok,
  output logic [5:0]       rd_idx,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_ok
);

  logic        aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic        awready_q, awready_d, wready_q, wready_d;
  logic        bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [5:0]  awidx_q, awidx_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0]  wstrb_q, wstrb_d;

  assign wr_en   = aw_full_q & w_full_q & ~bvalid_q;
  assign wr_idx  = awidx_q;
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;
  assign rd_idx  = s_araddr[7:2];

  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    awready_d = awready_q;
    wready_d  = wready_q;
    awidx_d   = awidx_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (s_awvalid && awready_q) begin
      aw_full_d = 1'b1;
      awready_d = 1'b0;
      awidx_d   = s_awaddr[7:2];
    end
    if (s_wvalid && wready_q) begin
      w_full_d = 1'b1;
      wready_d = 1'b0;
      wdata_d  = s_wdata;
      wstrb_d  = s_wstrb;
    end
    if (wr_en) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_ok ? dcfg_pkg::RESP_OKAY : dcfg_pkg::RESP_SLVERR;
    end
    if (bvalid_q && s_bready) begin
      bvalid_d  = 1'b0;
      awready_d = 1'b1;
      wready_d  = 1'b1;
    end
  end

  always_comb begin
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (s_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rdata_d   = rd_data;
      rresp_d   = rd_ok ? dcfg_pkg::RESP_OKAY : dcfg_pkg::RESP_SLVERR;
    end
    if (rvalid_q && s_rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      awidx_q   <= 6'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= dcfg_pkg::RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= dcfg_pkg::RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      awidx_q   <= awidx_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  assign s_awready = awready_q;
  assign s_wready  = wready_q;
  assign s_bvalid  = bvalid_q;
  assign s_bresp   = bresp_q;
  assign s_arready = arready_q;
  assign s_rvalid  = rvalid_q;
  assign s_rdata   = rdata_q;
  assign s_rresp   = rresp_q;

endmodule : dcfg_axil

`default_nettype wire

// ### design/dcfg_path.sv
/*
  DMA address forming and byte lane steering for one transfer.
  Purely combinational; the caller registers the results.
*/
`timescale 1ns/100ps
`default_nettype none

module dcfg_path (
  input  wire logic        word_mode,
  input  wire logic        lane_swap,
  input  wire logic        wide_mode,
  input  wire logic [15:0] start_hi,
  input  wire logic [15:0] xfer_idx,
  input  wire logic [15:0] data_in,
  output logic [31:0]      addr,
  output logic [15:0]      data_out
);

  logic [15:0] low_addr;

  always_comb begin
    // word index shifted up keeps A0 low and limits reach to 32k words
    low_addr = word_mode ? {xfer_idx[14:0], 1'b0} : xfer_idx;
    // dual mode leaves the upper half to the second 16-bit channel
    addr     = {(wide_mode ? start_hi : 16'h0000), low_addr};
    if (word_mode && lane_swap) begin
      data_out = {data_in[7:0], data_in[15:8]};
    end else begin
      data_out = data_in;
    end
  end

endmodule : dcfg_path

`default_nettype wire

// ### verif/dcfg_monitor.sv
/*
  Port checker for dcfg_top.
  Assumes it is bound to dcfg_top from the bench top.
*/
`timescale 1ns/100ps
`default_nettype none

module dcfg_monitor #(
  parameter int FIFO_LVL_W = 5
) (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [31:0]           mem_addr,
  input wire logic                  word_xfer,
  input wire logic [FIFO_LVL_W-1:0] fifo_level,
  input wire logic                  rx_active,
  input wire logic                  bus_req,
  input wire logic [4:0]            burst_len,
  input wire logic                  send_cmd,
  input wire logic                  auto_init_start,
  input wire logic                  send_ignored,
  input wire logic                  loopback_en,
  input wire logic [1:0]            loop_mode,
  input wire logic                  endec_loopback
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  word_addr_a: assert property (word_xfer && $past(word_xfer) && $past(word_xfer, 2)
    |-> !mem_addr[0]) else $error("odd address in word mode");
  send_go_a: assert property (auto_init_start |-> $past(send_cmd) && !send_ignored)
    else $error("send start without command");
  send_one_a: assert property (send_cmd |=> auto_init_start ^ send_ignored)
    else $error("send command not answered once");
  endec_mode_a: assert property (endec_loopback |-> loopback_en && loop_mode == 2'h2)
    else $error("endec loop without mode two");
  loop_off_a: assert property (!loopback_en |-> loop_mode == 2'h0)
    else $error("loop mode outside loopback");
  burst_set_a: assert property ($past(aresetn)
    |-> burst_len inside {5'h01, 5'h02, 5'h04, 5'h06, 5'h08, 5'h0C}) else $error("bad burst");
  low_fill_a: assert property (rx_active && fifo_level < 2 |=> !bus_req)
    else $error("bus request below threshold");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped");

  cover property (auto_init_start);
  cover property (endec_loopback);
  cover property ($rose(bus_req));
endmodule : dcfg_monitor

`default_nettype wire

// ### verif/dcfg_fifo_model.sv
/*
  Network side of the receive fifo: fill level walking toward a goal.
  Assumes the bench sets the goal; one byte per clock so every level is seen.
*/
`timescale 1ns/100ps
`default_nettype none

module dcfg_fifo_model #(
  parameter int FIFO_LVL_W = 5
) (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic [FIFO_LVL_W-1:0] lvl_goal,
  output logic [FIFO_LVL_W-1:0]     fifo_level
);
  logic [FIFO_LVL_W-1:0] lvl_q;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      lvl_q <= '0;
    else if (lvl_q < lvl_goal)
      lvl_q <= lvl_q + 1'b1;
    else if (lvl_q > lvl_goal)
      lvl_q <= lvl_q - 1'b1;
  end

  assign fifo_level = lvl_q;
endmodule : dcfg_fifo_model

`default_nettype wire

// ### verif/tb.sv
/*
  Bench for dcfg_top: AXI4-Lite master tasks, fifo model, checks.
  Assumes dcfg_pkg and dcfg_monitor are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic        aclk = 1'b0;
  logic        aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, dma_load, dma_step, word_xfer, rx_active, bus_req, send_cmd;
  logic        auto_init_start, send_ignored, loopback_en, endec_loopback;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, mem_addr, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, loop_mode;
  logic [15:0] dma_base, dma_wdata, mem_data;
  logic [4:0]  fifo_level, lvl_goal, burst_len, rx;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  localparam logic [7:0] A_RSA = {dcfg_pkg::IDX_RSA, 2'h0};
  localparam logic [7:0] A_TXC = {dcfg_pkg::IDX_TXC, 2'h0};
  localparam logic [7:0] A_DPC = {dcfg_pkg::IDX_DPC, 2'h0};
  localparam logic [7:0] A_ST  = {dcfg_pkg::IDX_STAT, 2'h0};
  localparam logic [1:0] OK = dcfg_pkg::RESP_OKAY;
  localparam logic [1:0] SE = dcfg_pkg::RESP_SLVERR;
  logic [7:0]  cv [5] = '{8'h0D, 8'h0F, 8'h0E, 8'h0D, 8'h09};
  logic [15:0] bv [5] = '{16'h0005, 16'h0005, 16'h0005, 16'hFFFF, 16'h0005};
  logic [31:0] av [5] = '{32'hABCD000A, 32'hABCD000A, 32'hABCD0005, 32'hABCDFFFE, 32'h0000000A};
  logic [15:0] dv [5] = '{16'h1234, 16'h3412, 16'h1234, 16'h1234, 16'h1234};

  dcfg_top dcfg_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .dma_load, .dma_base, .dma_step, .dma_wdata, .mem_addr,
    .mem_data, .word_xfer, .fifo_level, .rx_active, .bus_req, .burst_len, .send_cmd,
    .auto_init_start, .send_ignored, .loopback_en, .loop_mode, .endec_loopback);
  dcfg_fifo_model dcfg_fifo_model_inst (.aclk, .aresetn, .lvl_goal, .fifo_level);

  always #12.5 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic hang;
    n_mismatch++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    give_verdict();
  endtask : hang

  // ----
  // bus cycles: valids held until taken, ready held until answered
  // ----
  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    s_axi_bready <= 1'b0;
    if (n >= 100) hang();
    chk(s_axi_bresp, er, "bresp");
    @(posedge aclk);
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    s_axi_rready <= 1'b0;
    if (n >= 100) hang();
    v = s_axi_rdata;
    chk(s_axi_rresp, er, "rresp");
    @(posedge aclk);
  endtask : axr

  // bus_req is registered one edge after the level it compares
  task automatic fill(input logic [4:0] g, input logic exp);
    int n;
    lvl_goal <= g;
    for (n = 0; n < 40 && fifo_level !== g; n++) @(posedge aclk);
    if (n >= 40) hang();
    // second edge also covers a mode change made at the call
    repeat (2) @(posedge aclk);
    chk(bus_req, exp, "bus request");
  endtask : fill

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {dma_load, dma_step, rx_active, send_cmd, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, dma_base, dma_wdata, lvl_goal} = '0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axr(A_ST, d, OK);
    chk(d[7:0], 8'h04, "reset config");
    chk(loopback_en, 1'b1, "reset loop");
    axr(A_DPC, d, OK);
    chk(d, 32'h0, "write-only read");
    axw(8'hFC, 32'h1, SE);
    axr(8'hFC, d, SE);
    axw(A_DPC, 32'hFF, OK);
    axr(A_ST, d, OK);
    chk(d[7:0], 8'h7F, "top bit");
    rx_active <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rx = (i[1:0] == 2'h3) ? 5'h0C : (5'h02 << i[1:0]);
      axw(A_DPC, {24'h0, 1'b0, i[1:0], 4'b0110, i[2]}, OK);
      axr(A_ST, d, OK);
      chk(d[20:16], rx, "rx threshold");
      chk(d[28:24], 5'h0D - rx, "tx threshold");
      chk(burst_len, i[2] ? rx >> 1 : rx, "burst");
      chk(word_xfer, i[2], "width");
      fill(rx - 5'h01, 1'b0);
      fill(rx, 1'b1);
      rx_active <= 1'b0;
      fill(5'h0C - rx, 1'b0);
      fill(5'h0D - rx, 1'b1);
      rx_active <= 1'b1;
    end
    axw(A_RSA, 32'hABCD, OK);
    axr(A_RSA, d, OK);
    chk(d, 32'h0000ABCD, "start address");
    for (int i = 0; i < 5; i++) begin
      axw(A_DPC, {24'h0, cv[i]}, OK);
      dma_load <= 1'b1;
      dma_base <= bv[i];
      dma_wdata <= 16'h1234;
      @(posedge aclk);
      dma_load <= 1'b0;
      repeat (2) @(posedge aclk);
      chk(mem_addr, av[i], "dma address");
      chk(mem_data, dv[i], "byte lanes");
    end
    dma_step <= 1'b1;
    @(posedge aclk);
    dma_step <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(mem_addr, 32'h0000000C, "word step");
    for (int i = 0; i < 2; i++) begin
      axw(A_DPC, {24'h0, 3'h0, i[0], 4'b1100}, OK);
      send_cmd <= 1'b1;
      @(posedge aclk);
      send_cmd <= 1'b0;
      @(posedge aclk);
      chk(auto_init_start, i[0], "send start");
      chk(send_ignored, !i[0], "send ignored");
    end
    axw(A_DPC, 32'h04, OK);
    for (int m = 0; m < 5; m++) begin
      if (m == 4) axw(A_DPC, 32'h0C, OK);
      else axw(A_TXC, {29'h0, m[1:0], 1'b0}, OK);
      repeat (2) @(posedge aclk);
      chk(loopback_en, m < 4, "loopback");
      chk(loop_mode, (m < 4) ? m[1:0] : 2'h0, "loop mode");
      chk(endec_loopback, m == 2, "endec loop");
    end
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr(A_ST, d, OK);
    chk(d[7:0], 8'h04, "second reset");
    give_verdict();
  end
endmodule : tb

bind dcfg_top dcfg_monitor #(.FIFO_LVL_W(FIFO_LVL_W)) dcfg_monitor_inst (.aclk, .aresetn,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .mem_addr, .word_xfer, .fifo_level, .rx_active, .bus_req, .burst_len, .send_cmd,
  .auto_init_start, .send_ignored, .loopback_en, .loop_mode, .endec_loopback);

`default_nettype wire
